// File: uemr_regs.svh
// register offsets, field positions, reset values and mode codes of the endpoint responder
`ifndef UEMR_REGS_SVH
`define UEMR_REGS_SVH

`define UEMR_ADDR_W 5
`define UEMR_OFS_MODE0 5'h00
`define UEMR_OFS_MODE1 5'h04
`define UEMR_OFS_MODE2 5'h08
`define UEMR_OFS_CNT0 5'h0C
`define UEMR_OFS_CNT1 5'h10
`define UEMR_OFS_CNT2 5'h14
`define UEMR_OFS_TXDATA 5'h18
`define UEMR_OFS_STATUS 5'h1C

`define UEMR_MODE_MSB 3
`define UEMR_MODE_LSB 0
`define UEMR_STALL_BIT 7
`define UEMR_CNT_MSB 3
`define UEMR_MODE_RST 4'h0
`define UEMR_CNT_RST 4'h0

`define UEMR_M_DISABLE 4'h0
`define UEMR_M_NAK_INOUT 4'h1
`define UEMR_M_STATUS_OUT 4'h2
`define UEMR_M_STALL_INOUT 4'h3
`define UEMR_M_IGNORE_INOUT 4'h4
`define UEMR_M_RSVD_5 4'h5
`define UEMR_M_STATUS_IN 4'h6
`define UEMR_M_RSVD_7 4'h7
`define UEMR_M_NAK_OUT 4'h8
`define UEMR_M_ACK_OUT 4'h9
`define UEMR_M_NAKOUT_STIN 4'hA
`define UEMR_M_ACKOUT_NAKIN 4'hB
`define UEMR_M_NAK_IN 4'hC
`define UEMR_M_ACK_IN 4'hD
`define UEMR_M_NAKIN_STOUT 4'hE
`define UEMR_M_ACKIN_STOUT 4'hF

`define UEMR_FIFO_DEPTH 16
`define UEMR_FIFO_WIDTH 8

`endif

// File: uemr_pkg.sv
// types shared by the endpoint responder modules
package uemr_pkg;
   typedef enum logic [1:0] {
      UEMR_TOK_SETUP = 2'b00,
      UEMR_TOK_IN = 2'b01,
      UEMR_TOK_OUT = 2'b10
   } uemr_tok_e;

   typedef enum logic [2:0] {
      UEMR_RESP_NONE = 3'h0,
      UEMR_RESP_ACK = 3'h1,
      UEMR_RESP_NAK = 3'h2,
      UEMR_RESP_STALL = 3'h3,
      UEMR_RESP_DATA = 3'h4,
      UEMR_RESP_ZLP = 3'h5
   } uemr_resp_e;

   typedef enum logic [1:0] {
      UEMR_ST_IDLE = 2'b00,
      UEMR_ST_SEND = 2'b01
   } uemr_state_e;
endpackage : uemr_pkg

// File: uemr_fifo_if.sv
// push and pop channel of the transmit byte fifo
`timescale 1ns/1ps
interface uemr_fifo_if #(parameter int WIDTH = 8);
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WIDTH-1:0] out_data;
   logic [4:0] level;
   modport fifo (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data, level);
   modport user (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data, level);
endinterface : uemr_fifo_if

// File: uemr_fifo.sv
// transmit byte fifo with registered read data
`timescale 1ns/1ps
module uemr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   uemr_fifo_if.fifo ff
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || DEPTH > 16 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("fifo depth must be a power of two from 2 to 16");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] cnt_reg;
   logic out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;

   wire push = ff.in_valid && ff.in_ready;
   wire out_free = !out_valid_reg || ff.out_ready;
   wire pop = (cnt_reg != '0) && out_free;
   wire [AW:0] cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

   assign ff.in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign ff.out_valid = out_valid_reg;
   assign ff.out_data = out_data_reg;
   assign ff.level = 5'(cnt_reg) + 5'(out_valid_reg);

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= ff.in_data;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         cnt_reg <= cnt_next;
         if (out_free) begin
            out_valid_reg <= pop;
         end
         if (pop) begin
            out_data_reg <= mem[rd_ptr_reg];
         end
      end
   end
endmodule : uemr_fifo

// File: uemr_responder.sv
// endpoint mode registers, token response decode and transmit sequencing
//
// Contract
// - mode bits 3:0 select token response
// - mode 0000 answers nothing at all
// - 0001 acks setup, naks in and out
// - control setup ack forces mode 0001
// - 1011 naks in, acks out, then 0001
// - 1001 acks out then 1000; 1000 naks out
// - stall bit 7 of ep 1 and 2 stalls 1001 out, 1101 in
// - 1101 sends count, host ack gives 1100
// - 1111 sends count, ack gives 1110
// - status modes 0010, 0110, 1010 as listed
// - 0011 stalls in/out; 0100 ignores them
// - check acks only zero length toggle one
// - data in sends count field bytes
// - ignore means no handshake sent
// - modes reset to 0000, stay until written
`timescale 1ns/1ps
`include "uemr_regs.svh"
module uemr_responder #(
   parameter int FIFO_DEPTH = `UEMR_FIFO_DEPTH
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [`UEMR_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic tok_valid_i,
   output logic tok_ready_o,
   input wire logic [1:0] tok_kind_i,
   input wire logic [1:0] tok_ep_i,
   input wire logic tok_good_i,
   input wire logic [3:0] tok_len_i,
   input wire logic tok_toggle_i,
   input wire logic host_ack_i,
   output logic resp_valid_o,
   output logic [2:0] resp_code_o,
   output logic [1:0] resp_ep_o,
   output logic [3:0] resp_len_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [7:0] tx_data_o,
   output logic tx_last_o
);
   generate
      if (FIFO_DEPTH != 16 && FIFO_DEPTH != 8 && FIFO_DEPTH != 4) begin : g_bad_depth
         $error("fifo depth must be 4, 8 or 16");
      end
   endgenerate

   // ======================================================================
   // response decode
   function automatic uemr_pkg::uemr_resp_e decode_resp(
      input logic [3:0] mode,
      input logic stall,
      input uemr_pkg::uemr_tok_e tok,
      input logic good,
      input logic zero_tog1
   );
      uemr_pkg::uemr_resp_e r;
      uemr_pkg::uemr_resp_e chk;
      r = uemr_pkg::UEMR_RESP_NONE;
      chk = zero_tog1 ? uemr_pkg::UEMR_RESP_ACK : uemr_pkg::UEMR_RESP_STALL;
      case (tok)
         uemr_pkg::UEMR_TOK_SETUP: begin
            case (mode)
               `UEMR_M_NAK_INOUT, `UEMR_M_STATUS_OUT, `UEMR_M_STALL_INOUT,
               `UEMR_M_IGNORE_INOUT, `UEMR_M_STATUS_IN, `UEMR_M_NAKOUT_STIN,
               `UEMR_M_ACKOUT_NAKIN, `UEMR_M_NAKIN_STOUT, `UEMR_M_ACKIN_STOUT:
                  r = uemr_pkg::UEMR_RESP_ACK;
               default: r = uemr_pkg::UEMR_RESP_NONE;
            endcase
         end
         uemr_pkg::UEMR_TOK_IN: begin
            case (mode)
               `UEMR_M_NAK_INOUT, `UEMR_M_ACKOUT_NAKIN, `UEMR_M_NAK_IN,
               `UEMR_M_NAKIN_STOUT: r = uemr_pkg::UEMR_RESP_NAK;
               `UEMR_M_STATUS_OUT, `UEMR_M_STALL_INOUT: r = uemr_pkg::UEMR_RESP_STALL;
               `UEMR_M_STATUS_IN, `UEMR_M_NAKOUT_STIN: r = uemr_pkg::UEMR_RESP_ZLP;
               `UEMR_M_ACK_IN: r = stall ? uemr_pkg::UEMR_RESP_STALL
                                         : uemr_pkg::UEMR_RESP_DATA;
               `UEMR_M_ACKIN_STOUT, `UEMR_M_RSVD_7: r = uemr_pkg::UEMR_RESP_DATA;
               default: r = uemr_pkg::UEMR_RESP_NONE;
            endcase
         end
         uemr_pkg::UEMR_TOK_OUT: begin
            case (mode)
               `UEMR_M_NAK_INOUT, `UEMR_M_NAK_OUT,
               `UEMR_M_NAKOUT_STIN: r = uemr_pkg::UEMR_RESP_NAK;
               `UEMR_M_STALL_INOUT, `UEMR_M_STATUS_IN: r = uemr_pkg::UEMR_RESP_STALL;
               `UEMR_M_ACK_OUT: r = stall ? uemr_pkg::UEMR_RESP_STALL
                                          : uemr_pkg::UEMR_RESP_ACK;
               `UEMR_M_ACKOUT_NAKIN: r = uemr_pkg::UEMR_RESP_ACK;
               `UEMR_M_STATUS_OUT, `UEMR_M_NAKIN_STOUT,
               `UEMR_M_ACKIN_STOUT: r = chk;
               default: r = uemr_pkg::UEMR_RESP_NONE;
            endcase
         end
         default: r = uemr_pkg::UEMR_RESP_NONE;
      endcase
      // corrupt setup or out data gets no handshake
      if (tok != uemr_pkg::UEMR_TOK_IN && !good) begin
         r = uemr_pkg::UEMR_RESP_NONE;
      end
      return r;
   endfunction : decode_resp

   // ======================================================================
   // state
   logic [3:0] mode_reg [3];
   logic [3:0] mode_next [3];
   logic stall_reg [3];
   logic [3:0] cnt_reg [3];
   logic [31:0] rdata_reg;
   logic rd_done_reg;
   logic resp_valid_reg;
   uemr_pkg::uemr_resp_e resp_code_reg;
   logic [1:0] resp_ep_reg;
   logic [3:0] resp_len_reg;
   uemr_pkg::uemr_state_e state_reg;
   logic [3:0] left_reg;
   logic in_pend_reg;
   logic [1:0] in_ep_reg;

   uemr_fifo_if #(.WIDTH(`UEMR_FIFO_WIDTH)) ff ();

   uemr_fifo #(
      .WIDTH(`UEMR_FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ff(ff)
   );

   // ======================================================================
   // token decode
   wire ep_ok = tok_ep_i != 2'd3;
   wire [1:0] ep_sel = ep_ok ? tok_ep_i : 2'd0;
   wire [3:0] sel_mode = mode_reg[ep_sel];
   wire sel_stall = stall_reg[ep_sel];
   wire idle = state_reg == uemr_pkg::UEMR_ST_IDLE;
   wire tok_take = tok_valid_i && idle;
   wire zero_tog1 = (tok_len_i == 4'h0) && tok_toggle_i;
   wire uemr_pkg::uemr_tok_e tok_kind = uemr_pkg::uemr_tok_e'(tok_kind_i);
   wire uemr_pkg::uemr_resp_e tok_resp = ep_ok ?
      decode_resp(sel_mode, sel_stall, tok_kind, tok_good_i, zero_tog1)
      : uemr_pkg::UEMR_RESP_NONE;
   wire is_ack = tok_resp == uemr_pkg::UEMR_RESP_ACK;
   wire setup_ack = tok_take && is_ack && tok_kind == uemr_pkg::UEMR_TOK_SETUP;
   wire out_ack = tok_take && is_ack && tok_kind == uemr_pkg::UEMR_TOK_OUT;
   wire [3:0] send_len = (tok_resp == uemr_pkg::UEMR_RESP_DATA) ? cnt_reg[ep_sel] : 4'h0;
   wire goes_send = tok_take && tok_resp == uemr_pkg::UEMR_RESP_DATA && send_len != 4'h0;
   wire sends_in = tok_take && (tok_resp == uemr_pkg::UEMR_RESP_DATA ||
                                tok_resp == uemr_pkg::UEMR_RESP_ZLP);
   wire in_acked = host_ack_i && in_pend_reg;

   // ======================================================================
   // register bus
   wire [2:0] widx = avs_address[4:2];
   wire bus_mode_wr = avs_write && avs_byteenable[0] && widx <= 3'd2;
   wire bus_cnt_wr = avs_write && avs_byteenable[0] && widx >= 3'd3 && widx <= 3'd5;
   wire bus_tx_wr = avs_write && avs_byteenable[0] && avs_address == `UEMR_OFS_TXDATA;
   wire [31:0] rd_mux =
      (widx <= 3'd2) ? {24'h0, (widx != 3'd0) && stall_reg[widx[1:0]], 3'h0,
                        mode_reg[widx[1:0]]} :
      (widx <= 3'd5) ? {28'h0, cnt_reg[2'(widx - 3'd3)]} :
      (avs_address == `UEMR_OFS_STATUS) ? {16'h0, 3'h0, ff.level, 1'b0, resp_code_reg,
                                           2'h0, in_pend_reg, !idle} :
      32'h0;

   assign ff.in_valid = bus_tx_wr;
   assign ff.in_data = avs_writedata[7:0];
   assign avs_waitrequest = (avs_read && !rd_done_reg) || (bus_tx_wr && !ff.in_ready);
   assign avs_readdata = rdata_reg;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rd_done_reg <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         rd_done_reg <= avs_read && !rd_done_reg;
         if (avs_read && !rd_done_reg) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   // ======================================================================
   // per endpoint mode and count
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ep
         wire hit = ep_ok && tok_ep_i == 2'(g);
         wire fw_mode = bus_mode_wr && widx == 3'(g);
         wire fw_cnt = bus_cnt_wr && widx == 3'(g + 3);
         wire in_hit = in_acked && in_ep_reg == 2'(g);
         always_comb begin
            mode_next[g] = mode_reg[g];
            if (fw_mode) begin
               mode_next[g] = avs_writedata[`UEMR_MODE_MSB:`UEMR_MODE_LSB];
            end
            // engine updates win over a firmware write in the same cycle
            if (g == 0 && hit && setup_ack && mode_reg[g] != `UEMR_M_DISABLE) begin
               mode_next[g] = `UEMR_M_NAK_INOUT;
            end
            if (hit && out_ack && mode_reg[g] == `UEMR_M_ACKOUT_NAKIN) begin
               mode_next[g] = `UEMR_M_NAK_INOUT;
            end
            if (hit && out_ack && mode_reg[g] == `UEMR_M_ACK_OUT) begin
               mode_next[g] = `UEMR_M_NAK_OUT;
            end
            if (in_hit && mode_reg[g] == `UEMR_M_ACK_IN) begin
               mode_next[g] = `UEMR_M_NAK_IN;
            end
            if (in_hit && mode_reg[g] == `UEMR_M_ACKIN_STOUT) begin
               mode_next[g] = `UEMR_M_NAKIN_STOUT;
            end
         end
         always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               mode_reg[g] <= `UEMR_MODE_RST;
               stall_reg[g] <= 1'b0;
               cnt_reg[g] <= `UEMR_CNT_RST;
            end else begin
               mode_reg[g] <= mode_next[g];
               if (fw_mode && g != 0) begin
                  stall_reg[g] <= avs_writedata[`UEMR_STALL_BIT];
               end
               if (fw_cnt) begin
                  cnt_reg[g] <= avs_writedata[`UEMR_CNT_MSB:0];
               end
            end
         end
      end
   endgenerate

   // ======================================================================
   // handshake and transmit sequencing
   assign tok_ready_o = idle;
   assign resp_valid_o = resp_valid_reg;
   assign resp_code_o = resp_code_reg;
   assign resp_ep_o = resp_ep_reg;
   assign resp_len_o = resp_len_reg;
   assign ff.out_ready = (state_reg == uemr_pkg::UEMR_ST_SEND) && tx_ready_i;
   assign tx_valid_o = (state_reg == uemr_pkg::UEMR_ST_SEND) && ff.out_valid;
   assign tx_data_o = ff.out_data;
   assign tx_last_o = left_reg == 4'h1;

   wire tx_beat = tx_valid_o && tx_ready_i;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         resp_valid_reg <= 1'b0;
         resp_code_reg <= uemr_pkg::UEMR_RESP_NONE;
         resp_ep_reg <= 2'd0;
         resp_len_reg <= 4'h0;
      end else begin
         resp_valid_reg <= tok_take && tok_resp != uemr_pkg::UEMR_RESP_NONE;
         if (tok_take) begin
            resp_code_reg <= tok_resp;
            resp_ep_reg <= tok_ep_i;
            resp_len_reg <= send_len;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_reg <= uemr_pkg::UEMR_ST_IDLE;
         left_reg <= 4'h0;
      end else begin
         case (state_reg)
            uemr_pkg::UEMR_ST_IDLE: begin
               if (goes_send) begin
                  state_reg <= uemr_pkg::UEMR_ST_SEND;
                  left_reg <= send_len;
               end
            end
            uemr_pkg::UEMR_ST_SEND: begin
               if (tx_beat) begin
                  left_reg <= left_reg - 4'h1;
                  if (left_reg == 4'h1) begin
                     state_reg <= uemr_pkg::UEMR_ST_IDLE;
                  end
               end
            end
            default: state_reg <= uemr_pkg::UEMR_ST_IDLE;
         endcase
      end
   end

   // host ack for in data counts only until the next token
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         in_pend_reg <= 1'b0;
         in_ep_reg <= 2'd0;
      end else if (tok_take) begin
         in_pend_reg <= sends_in;
         in_ep_reg <= tok_ep_i;
      end else if (in_acked) begin
         in_pend_reg <= 1'b0;
      end
   end
endmodule : uemr_responder

// File: uemr_properties.sv
// concurrent checks on the endpoint responder ports
`timescale 1ns/1ps
module uemr_properties #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic avs_read,
   input wire logic avs_waitrequest,
   input wire logic tok_valid_i,
   input wire logic tok_ready_o,
   input wire logic [1:0] tok_kind_i,
   input wire logic [1:0] tok_ep_i,
   input wire logic tok_good_i,
   input wire logic resp_valid_o,
   input wire logic [2:0] resp_code_o,
   input wire logic [1:0] resp_ep_o,
   input wire logic [3:0] resp_len_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic tx_last_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic [3:0] beat_reg;
   wire take = tok_valid_i && tok_ready_o;
   wire beat = tx_valid_o && tx_ready_i;
   wire [3:0] beat_now = resp_valid_o ? 4'h0 : beat_reg;
   // bytes already sent in the current data stream
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) beat_reg <= 4'h0;
      else if (beat) beat_reg <= beat_now + 4'h1;
      else if (resp_valid_o) beat_reg <= 4'h0;
   end
   AST_RESET_QUIET: assert property ($rose(rst_n_i) |-> !resp_valid_o && resp_code_o == 3'h0
      && tok_ready_o && !tx_valid_o) else $error("responder busy out of reset");
   AST_RESP_NOT_NONE: assert property (resp_valid_o |-> resp_code_o != 3'h0)
      else $error("response pulse without handshake");
   AST_RESP_AFTER_TOKEN: assert property (resp_valid_o |-> $past(take))
      else $error("response without a token");
   AST_BAD_DATA_SILENT: assert property (take && tok_kind_i != 2'h1 && !tok_good_i
      |=> !resp_valid_o) else $error("answer to a broken data packet");
   AST_RESP_EP: assert property (take |=> !resp_valid_o || resp_ep_o == $past(tok_ep_i))
      else $error("response names wrong endpoint");
   AST_CODE_HOLDS: assert property (!take |=> $stable(resp_code_o) && $stable(resp_ep_o))
      else $error("response changed without token");
   AST_STREAM_BLOCKS: assert property (resp_valid_o && resp_code_o == 3'h4
      && resp_len_o != 4'h0 |-> !tok_ready_o) else $error("data stream did not start");
   AST_STREAM_HOLDS_TOKENS: assert property (tx_valid_o |-> !tok_ready_o)
      else $error("token accepted while streaming");
   AST_LAST_COUNT: assert property (beat && tx_last_o |-> beat_now == resp_len_o - 4'h1
      ##1 tok_ready_o) else $error("stream length differs from count");
   AST_READ_ONE_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest
      ##1 !avs_waitrequest) else $error("read wait state count wrong");
endmodule : uemr_properties
bind uemr_responder uemr_properties #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_read(avs_read),
   .avs_waitrequest(avs_waitrequest), .tok_valid_i(tok_valid_i), .tok_ready_o(tok_ready_o),
   .tok_kind_i(tok_kind_i), .tok_ep_i(tok_ep_i), .tok_good_i(tok_good_i),
   .resp_valid_o(resp_valid_o), .resp_code_o(resp_code_o), .resp_ep_o(resp_ep_o),
   .resp_len_o(resp_len_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
   .tx_last_o(tx_last_o));

// File: uemr_host_model.sv
// usb host stand-in: offers tokens, acks data packets, paces the byte sink
`timescale 1ns/1ps
module uemr_host_model (
   input wire logic core_clk_i,
   input wire logic slow_i,
   input wire logic tok_ready_i,
   output logic tok_valid_o,
   output logic [1:0] tok_kind_o,
   output logic [1:0] tok_ep_o,
   output logic tok_good_o,
   output logic [3:0] tok_len_o,
   output logic tok_toggle_o,
   output logic host_ack_o,
   output logic tx_ready_o
);
   logic [1:0] pace_reg;
   initial begin
      tok_valid_o = 1'b0;
      {tok_kind_o, tok_ep_o, tok_good_o, tok_len_o, tok_toggle_o} = 10'h0;
      host_ack_o = 1'b0;
      tx_ready_o = 1'b1;
      pace_reg = 2'h0;
   end
   // slow sink takes one byte in four
   always @(posedge core_clk_i) begin
      pace_reg <= pace_reg + 2'h1;
      tx_ready_o <= !slow_i || pace_reg == 2'h0;
   end
   task automatic token(input logic [1:0] k, input logic [1:0] e, input logic g,
         input logic [3:0] l, input logic t);
      @(posedge core_clk_i);
      tok_valid_o <= 1'b1;
      {tok_kind_o, tok_ep_o, tok_good_o, tok_len_o, tok_toggle_o} <= {k, e, g, l, t};
      do @(negedge core_clk_i); while (!tok_ready_i);
      @(posedge core_clk_i);
      tok_valid_o <= 1'b0;
      // released fields never keep the last value
      {tok_kind_o, tok_ep_o, tok_good_o, tok_len_o, tok_toggle_o} <= ~{k, e, g, l, t};
   endtask : token
   // ack only once the data packet has been sent
   task automatic ack();
      do @(negedge core_clk_i); while (!tok_ready_i);
      @(posedge core_clk_i);
      host_ack_o <= 1'b1;
      @(posedge core_clk_i);
      host_ack_o <= 1'b0;
   endtask : ack
endmodule : uemr_host_model

// File: tb.sv
// self-checking bench for the endpoint responder
`timescale 1ns/1ps
module tb;
   logic core_clk_i, rst_n_i, avs_read, avs_write, avs_waitrequest, slow;
   logic tok_valid_i, tok_ready_o, tok_good_i, tok_toggle_i, host_ack_i, resp_valid_o;
   logic tx_valid_o, tx_ready_i, tx_last_o;
   logic [1:0] tok_kind_i, tok_ep_i, resp_ep_o;
   logic [2:0] resp_code_o;
   logic [3:0] tok_len_i, resp_len_o;
   logic [4:0] avs_address;
   logic [7:0] tx_data_o;
   logic [31:0] avs_writedata, avs_readdata;
   logic [31:0] seed = 32'h00015E55;
   int fail_count, n_checks, cyc, wmax;
   logic [31:0] rdq[$];
   logic [8:0] rq[$];
   logic [8:0] txq[$];
   // per mode {setup, in, out}: 6 check, 7 send count
   logic [8:0] rows [16] = '{9'h000, 9'h052, 9'h05E, 9'h05B, 9'h040, 9'h000, 9'h06B, 9'h000,
      9'h002, 9'h001, 9'h06A, 9'h051, 9'h010, 9'h038, 9'h056, 9'h07E};
   uemr_responder #(.FIFO_DEPTH(16)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .tok_valid_i(tok_valid_i), .tok_ready_o(tok_ready_o),
      .tok_kind_i(tok_kind_i), .tok_ep_i(tok_ep_i), .tok_good_i(tok_good_i),
      .tok_len_i(tok_len_i), .tok_toggle_i(tok_toggle_i), .host_ack_i(host_ack_i),
      .resp_valid_o(resp_valid_o), .resp_code_o(resp_code_o), .resp_ep_o(resp_ep_o),
      .resp_len_o(resp_len_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
      .tx_data_o(tx_data_o), .tx_last_o(tx_last_o));
   uemr_host_model i_host (.core_clk_i(core_clk_i), .slow_i(slow), .tok_ready_i(tok_ready_o),
      .tok_valid_o(tok_valid_i), .tok_kind_o(tok_kind_i), .tok_ep_o(tok_ep_i),
      .tok_good_o(tok_good_i), .tok_len_o(tok_len_i), .tok_toggle_o(tok_toggle_i),
      .host_ack_o(host_ack_i), .tx_ready_o(tx_ready_i));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   function automatic logic [2:0] exp_resp(input logic [3:0] m, input logic st,
         input logic [1:0] k, input logic g, input logic [3:0] l, input logic t);
      logic [2:0] r;
      r = k == 2'h0 ? rows[m][8:6] : k == 2'h1 ? rows[m][5:3] : rows[m][2:0];
      if (r == 3'h7) r = 3'h4;
      if (r == 3'h6) r = (l == 4'h0 && t) ? 3'h1 : 3'h3;
      if (st && r != 3'h0 && (m == 4'h9 && k == 2'h2 || m == 4'hD && k == 2'h1)) r = 3'h3;
      if (k != 2'h1 && !g) r = 3'h0;
      return r;
   endfunction : exp_resp
   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      n_checks++;
      if (a !== e) begin
         fail_count++;
         $display("[FAIL] %0t expected %h got %h", $time, e, a);
      end
   endtask : chk
   task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_i);
      avs_address <= a;
      avs_write <= wr_en;
      avs_read <= !wr_en;
      avs_writedata <= d;
      n = 0;
      do begin
         @(negedge core_clk_i);
         n++;
      end while (avs_waitrequest);
      @(posedge core_clk_i);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (wr_en && n > wmax) wmax = n;
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      rdq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd
   // directed token on a freshly written mode, good packet, zero length, toggle one
   task automatic step(input logic [1:0] ep, input logic [7:0] m, input logic [1:0] k,
         input logic [2:0] e, input logic [7:0] nx);
      bus(1'b1, {1'b0, ep, 2'b00}, {24'h0, m});
      rq.push_back({e, ep, 4'h0});
      i_host.token(k, ep, 1'b1, 4'h0, 1'b1);
      rd({1'b0, ep, 2'b00}, {24'h0, nx});
   endtask : step
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   // ==========================================
   // monitor: oldest note against each result
   always @(negedge core_clk_i) begin
      if (rst_n_i && avs_read && !avs_waitrequest)
         chk(rdq.size() ? rdq.pop_front() : 32'hX, avs_readdata);
      if (resp_valid_o) chk({23'h0, rq.size() ? rq.pop_front() : 9'h1FF}, {23'h0, resp_code_o,
         resp_ep_o, resp_code_o == 3'h4 ? resp_len_o : 4'h0});
      if (tx_valid_o && tx_ready_i)
         chk({23'h0, txq.size() ? txq.pop_front() : 9'h1FF}, {23'h0, tx_last_o, tx_data_o});
   end
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         results();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      logic [31:0] r;
      logic [3:0] m, nx;
      logic [2:0] e;
      logic [1:0] ep;
      logic st;
      rst_n_i = 1'b0;
      {avs_read, avs_write, slow} = 3'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 3; i++) rd(5'(i * 4), 32'h0);
      rd(5'h18, 32'h0);
      for (int mi = 0; mi < 16; mi++) begin
         if (mi == 5 || mi == 7) continue;
         for (int k = 0; k < 3; k++) begin
            r = rnd();
            m = mi[3:0];
            ep = 2'((mi + k) % 3);
            st = r[8] && ep != 2'h0;
            bus(1'b1, {1'b0, ep, 2'b00}, {24'h0, st, 3'h0, m});
            e = exp_resp(m, st, k[1:0], r[2] | r[3], r[0] ? 4'h0 : r[7:4], r[1]);
            if (e != 3'h0) rq.push_back({e, ep, 4'h0});
            i_host.token(k[1:0], ep, r[2] | r[3], r[0] ? 4'h0 : r[7:4], r[1]);
            nx = (e == 3'h1 && (k == 0 && ep == 0 || k == 2 && m == 4'hB)) ? 4'h1 :
               (e == 3'h1 && k == 2 && m == 4'h9) ? 4'h8 : m;
            rd({1'b0, ep, 2'b00}, {24'h0, st, 3'h0, nx});
         end
      end
      step(2'h2, 8'h09, 2'h2, 3'h1, 8'h08);
      step(2'h2, 8'h89, 2'h2, 3'h3, 8'h89);
      step(2'h1, 8'h0B, 2'h2, 3'h1, 8'h01);
      step(2'h1, 8'h8D, 2'h1, 3'h3, 8'h8D);
      step(2'h0, 8'h0E, 2'h2, 3'h1, 8'h0E);
      step(2'h0, 8'h0F, 2'h0, 3'h1, 8'h01);
      bus(1'b1, 5'h04, 32'h0D);
      bus(1'b1, 5'h10, 32'h0F);
      slow <= 1'b1;
      fork
         for (int i = 0; i < 18; i++) begin
            r = rnd();
            txq.push_back({i == 14 || i == 17, r[7:0]});
            bus(1'b1, 5'h18, r);
         end
         begin
            repeat (50) @(posedge core_clk_i);
            rq.push_back({3'h4, 2'h1, 4'hF});
            i_host.token(2'h1, 2'h1, 1'b1, 4'h0, 1'b0);
         end
      join
      chk({31'h0, wmax > 3}, 32'h1);
      i_host.ack();
      rd(5'h04, 32'h0C);
      rq.push_back({3'h2, 2'h1, 4'h0});
      i_host.token(2'h1, 2'h1, 1'b1, 4'h0, 1'b0);
      bus(1'b1, 5'h08, 32'h0F);
      bus(1'b1, 5'h14, 32'h03);
      rq.push_back({3'h4, 2'h2, 4'h3});
      i_host.token(2'h1, 2'h2, 1'b1, 4'h0, 1'b0);
      i_host.ack();
      rd(5'h08, 32'h0E);
      repeat (4) @(posedge core_clk_i);
      chk(rdq.size() + rq.size() + txq.size(), 32'h0);
      results();
   end
endmodule : tb
